// >>> dram_card_host.sv
// Host controller driving an asynchronous multiplexed-address memory card.
// Assumes card pins are sampled on the 50 MHz clock; tristate resolved outside.
//
// Functional notes
// - Reads keep write-enable high until the column strobe has risen.
// - Hidden refresh after a write keeps write-enable low throughout.
// - Test entry: write-enable low around a column-first refresh sequence.
// - Late write: output-enable high, write-enable falls after column strobe.
// - With output-enable tied low only early writes are issued.
// - RMW writes raise output-enable for disable time before data; late writes keep it high throughout.
// - All 512 rows refreshed within every 64 ms.
// - Row-only refresh drives the row on the address; write-enable ignored.
// - Wait 100 us then eight refreshes; repeat when interval overrun.
`timescale 1ns/1ps
module dram_card_host
  import dram_card_host_pkg::*;
#(
  parameter logic [15:0] INIT_WAIT = INIT_CYC,
  parameter logic [15:0] ROW_INTERVAL = ROW_INTERVAL_CYC,
  parameter logic [15:0] OPEN_ROW_LIMIT = OPEN_ROW_CYC
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic wide_mode,
  input wire logic oe_tied_low,
  input wire logic req_valid,
  input wire request_s req,
  output logic req_ready,
  output logic ans_valid,
  output answer_s ans,
  output logic card_ready,
  output card_pins_s pins,
  input wire logic [39:0] data_lines_in
);

  typedef enum logic [3:0] {
    S_POWER_WAIT = 4'b0000,
    S_IDLE = 4'b0001,
    S_ROW = 4'b0010,
    S_COL = 4'b0011,
    S_OE_OFF = 4'b0100,
    S_LATE_WE = 4'b0101,
    S_COL_END = 4'b0110,
    S_OPEN = 4'b0111,
    S_PRECHARGE = 4'b1000,
    S_REF_SETUP = 4'b1001,
    S_REF_RAS = 4'b1010,
    S_HIDDEN_UP = 4'b1011,
    S_HIDDEN_DN = 4'b1100
  } state_e;

  typedef struct packed {
    state_e st;
    logic [15:0] cnt;
    logic [15:0] open_cnt;
    cmd_e kind;
    request_s req;
    logic pend;
    logic auto_ref;
    logic [3:0] wake_left;
    logic [8:0] ref_row;
    logic req_ready;
    logic ans_valid;
    answer_s ans;
    logic card_ready;
    logic ref_done;
    card_pins_s pins;
  } host_state_s;

  host_state_s s;
  host_state_s n;
  logic due;
  logic overdue;
  logic take;
  logic hit;

  refresh_pacer #(.ROW_INTERVAL(ROW_INTERVAL)) pacer (
    .clock(clock),
    .rst(rst),
    .taken(s.ref_done),
    .due(due),
    .overdue(overdue)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Decoders

  function automatic logic is_refresh(input cmd_e k);
    return k[2];
  endfunction

  function automatic logic is_late(input cmd_e k);
    return (k == CMD_WRITE_LATE) || (k == CMD_READ_MODIFY_WRITE);
  endfunction

  // Active-high row strobe choice: wide pairs 0/2 and 1/3, narrow one-hot
  function automatic logic [3:0] ras_select(input logic [1:0] bank, input logic wide);
    if (wide)
      return bank[0] ? 4'ha : 4'h5;
    return 4'h1 << bank;
  endfunction

  // Narrow mode joins lanes 0/2 and 1/3 on the host
  function automatic logic [3:0] lane_select(input logic [3:0] lanes, input logic wide);
    return wide ? lanes : {lanes[1:0], lanes[1:0]};
  endfunction

  // Starts a card cycle of kind k from an all-strobes-high state
  function automatic host_state_s launch(input host_state_s t, input cmd_e k);
    t.kind = k;
    t.cnt = 16'h0000;
    if (is_refresh(k))
    begin
      t.st = S_REF_SETUP;
      t.pins.cas_n = (k == CMD_ROW_ONLY_REFRESH) ? 4'hf : 4'h0;
      t.pins.we_n = (k != CMD_TEST_ENTRY);
      t.pins.multiplexed_address = (k == CMD_ROW_ONLY_REFRESH) ? t.ref_row : 9'h000;
    end
    else
    begin
      t.st = S_ROW;
      t.pins.multiplexed_address = t.req.row;
    end
    return t;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    n = s;
    n.ans_valid = 1'b0;
    n.ref_done = 1'b0;
    n.cnt = s.cnt + 16'h0001;
    take = s.req_ready && req_valid;
    hit = !is_refresh(req.cmd) && req.bank == s.req.bank && req.row == s.req.row;
    if (overdue && s.card_ready && s.wake_left == 4'h0)
      n.wake_left = WAKE_COUNT;
    unique case (s.st)
      S_POWER_WAIT:
      begin
        if (s.cnt == INIT_WAIT - 16'h0001)
        begin
          n.st = S_IDLE;
          n.wake_left = WAKE_COUNT;
        end
      end
      S_IDLE, S_OPEN:
      begin
        n.open_cnt = s.open_cnt + 16'h0001;
        if (take && oe_tied_low && is_late(req.cmd))
        begin
          n.ans_valid = 1'b1;
          n.ans.err = 1'b1;
        end
        else if (take && s.st == S_OPEN && hit)
        begin
          n.req = req;
          n.kind = req.cmd;
          n.st = S_ROW;
          n.cnt = 16'h0001;
        end
        else if (take)
        begin
          n.req = req;
          n.auto_ref = 1'b0;
          if (s.st == S_OPEN)
          begin
            n.st = S_PRECHARGE;
            n.pins = PINS_IDLE;
            n.pend = 1'b1;
            n.cnt = 16'h0000;
          end
          else
            n = launch(n, req.cmd);
        end
        else if (s.st == S_OPEN &&
                 (due || s.wake_left != 4'h0 || s.open_cnt == OPEN_ROW_LIMIT - 16'h0001))
        begin
          n.st = S_PRECHARGE;
          n.pins = PINS_IDLE;
          n.cnt = 16'h0000;
        end
        else if (s.st == S_IDLE && (due || s.wake_left != 4'h0))
        begin
          n.auto_ref = 1'b1;
          n = launch(n, CMD_COLUMN_FIRST_REFRESH);
        end
      end
      S_ROW:
      begin
        if (s.cnt == 16'h0000)
          n.pins.ras_n = ~ras_select(s.req.bank, wide_mode);
        else if (s.cnt == 16'h0001)
        begin
          n.pins.multiplexed_address = s.req.col;
          n.pins.we_n = (s.kind != CMD_WRITE_EARLY);
          n.pins.oe_n = !(s.kind == CMD_READ || s.kind == CMD_READ_MODIFY_WRITE);
          n.pins.data_lines_out = s.req.wdata;
          n.pins.data_lines_drive_n = (s.kind != CMD_WRITE_EARLY);
        end
        else
        begin
          n.pins.cas_n = ~lane_select(s.req.lanes, wide_mode);
          n.st = S_COL;
          n.cnt = 16'h0000;
        end
      end
      S_COL:
      begin
        if ((s.kind == CMD_READ || s.kind == CMD_READ_MODIFY_WRITE) &&
            s.cnt == CAC_CYC - 16'h0001)
          n.ans.rdata = data_lines_in;
        unique case (s.kind)
          CMD_WRITE_LATE:
          begin
            n.st = S_LATE_WE;
            n.pins.we_n = 1'b0;
            n.pins.data_lines_drive_n = 1'b0;
            n.cnt = 16'h0000;
          end
          CMD_READ_MODIFY_WRITE:
          begin
            if (s.cnt == RMW_WE_CYC - 16'h0001)
            begin
              n.st = S_OE_OFF;
              n.pins.oe_n = 1'b1;
              n.cnt = 16'h0000;
            end
          end
          default:
          begin
            if (s.cnt == ((s.kind == CMD_READ) ? CAC_CYC : CAS_CYC) - 16'h0001)
              n.st = S_COL_END;
          end
        endcase
      end
      S_OE_OFF:
      begin
        if (s.cnt == OD_CYC - 16'h0001)
        begin
          n.st = S_LATE_WE;
          n.pins.we_n = 1'b0;
          n.pins.data_lines_drive_n = 1'b0;
          n.cnt = 16'h0000;
        end
      end
      S_LATE_WE:
      begin
        if (s.cnt == CWL_CYC - 16'h0001)
          n.st = S_COL_END;
      end
      S_COL_END:
      begin
        // Strobe already up; release write-enable and data one cycle later
        n.st = S_OPEN;
        n.pins.we_n = 1'b1;
        n.pins.oe_n = 1'b1;
        n.pins.data_lines_drive_n = 1'b1;
        n.open_cnt = 16'h0000;
      end
      S_HIDDEN_UP:
      begin
        if (s.cnt == RP_CYC - 16'h0001)
        begin
          n.st = S_HIDDEN_DN;
          n.pins.ras_n = 4'h0;
          n.cnt = 16'h0000;
        end
      end
      S_REF_SETUP:
      begin
        n.st = S_REF_RAS;
        n.pins.ras_n = 4'h0;
        n.cnt = 16'h0000;
      end
      S_HIDDEN_DN, S_REF_RAS:
      begin
        if (s.cnt == RAS_CYC - 16'h0001)
        begin
          n.st = S_PRECHARGE;
          n.pins = PINS_IDLE;
          n.cnt = 16'h0000;
          n.ref_done = s.auto_ref || s.st == S_HIDDEN_DN;
          if (s.kind == CMD_ROW_ONLY_REFRESH)
            n.ref_row = s.ref_row + 9'h001;
          if (s.auto_ref && s.wake_left != 4'h0)
            n.wake_left = s.wake_left - 4'h1;
          if (s.auto_ref && s.wake_left == 4'h1)
            n.card_ready = 1'b1;
          if (!s.auto_ref && s.st == S_REF_RAS)
          begin
            n.ans_valid = 1'b1;
            n.ans.err = 1'b0;
          end
        end
      end
      S_PRECHARGE:
      begin
        if (s.cnt == RP_CYC - 16'h0001)
        begin
          n.st = S_IDLE;
          if (s.pend)
          begin
            n.pend = 1'b0;
            n = launch(n, s.req.cmd);
          end
        end
      end
      default:
      begin
        n.st = S_PRECHARGE;
        n.pins = PINS_IDLE;
        n.cnt = 16'h0000;
      end
    endcase
    // Leaving the column phase: answer, then close column or hide a refresh
    if ((s.st == S_COL || s.st == S_LATE_WE) && n.st == S_COL_END)
    begin
      n.ans_valid = 1'b1;
      n.ans.err = 1'b0;
      if (s.req.hidden)
      begin
        n.st = S_HIDDEN_UP;
        n.pins.ras_n = 4'hf;
        n.pins.data_lines_drive_n = 1'b1;
        n.cnt = 16'h0000;
      end
      else
        n.pins.cas_n = 4'hf;
    end
    n.req_ready = (n.st == S_IDLE || n.st == S_OPEN) && n.wake_left == 4'h0 && !due;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.pins <= PINS_IDLE;
    end
    else
      s <= n;
  end

  assign req_ready = s.req_ready;
  assign ans_valid = s.ans_valid;
  assign ans = s.ans;
  assign card_ready = s.card_ready;
  assign pins = s.pins;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic [3:0] wake_done;
  logic [15:0] cas_low_cnt;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wake_done <= 4'h0;
      cas_low_cnt <= 16'h0000;
    end
    else
    begin
      if (s.ref_done && !s.card_ready)
        wake_done <= wake_done + 4'h1;
      cas_low_cnt <= (s.pins.cas_n == 4'hf) ? 16'h0000 : cas_low_cnt + 16'h0001;
    end
  end

  sequence s_rmw_drain;
    (s.pins.oe_n && s.pins.data_lines_drive_n) [*2] ##1
      (!s.pins.we_n && !s.pins.data_lines_drive_n);
  endsequence

  a_read_we_high: assert property (
    (s.st == S_COL_END && s.kind == CMD_READ) |-> s.pins.we_n && $past(s.pins.we_n, 2))
    else $error("write-enable low during read");
  a_hidden_we_low: assert property (
    (s.st == S_HIDDEN_DN && s.kind == CMD_WRITE_EARLY) |-> !s.pins.we_n)
    else $error("write-enable rose in hidden refresh after write");
  a_test_we_window: assert property (
    (s.st == S_REF_RAS && s.cnt == 16'h0000 && s.kind == CMD_TEST_ENTRY) |->
      !s.pins.we_n && !$past(s.pins.we_n) && s.pins.cas_n == 4'h0 ##1 !s.pins.we_n)
    else $error("test entry write-enable window broken");
  a_early_we_first: assert property (
    (s.st == S_COL && s.cnt == 16'h0000 && s.kind == CMD_WRITE_EARLY) |->
      !$past(s.pins.we_n) && !s.pins.data_lines_drive_n)
    else $error("early write not set up before column strobe");
  a_rmw_we_delay: assert property (
    ($fell(s.pins.we_n) && s.kind == CMD_READ_MODIFY_WRITE) |->
      cas_low_cnt >= CWD_CYC && cas_low_cnt >= AWD_CYC)
    else $error("read-modify-write strobe too early");
  a_rmw_turnaround: assert property (
    (s.st == S_OE_OFF && $rose(s.pins.oe_n) && s.kind == CMD_READ_MODIFY_WRITE) |->
      s_rmw_drain)
    else $error("data driven before outputs disabled");
  a_late_oe_high: assert property (
    ($fell(s.pins.we_n) && is_late(s.kind) && s.pins.cas_n != 4'hf) |->
      s.pins.oe_n ##1 s.pins.oe_n)
    else $error("output-enable low around late write");
  a_tied_refused: assert property (
    (take && oe_tied_low && is_late(req.cmd)) |=> s.ans_valid && s.ans.err)
    else $error("late write issued with output-enable tied");
  a_row_only_addr: assert property (
    (s.st == S_REF_RAS && s.kind == CMD_ROW_ONLY_REFRESH) |->
      s.pins.multiplexed_address == s.ref_row && s.pins.cas_n == 4'hf)
    else $error("row-only refresh address wrong");
  a_column_first_order: assert property (
    (s.st == S_REF_RAS && s.cnt == 16'h0000 && s.kind != CMD_ROW_ONLY_REFRESH) |->
      $past(s.pins.cas_n) == 4'h0 && $past(s.pins.ras_n) == 4'hf)
    else $error("column strobe not ahead of row strobe");
  a_page_row_held: assert property (
    (s.st == S_OPEN) |-> s.pins.ras_n != 4'hf && s.pins.cas_n == 4'hf)
    else $error("open page lost its row strobe");
  a_wake_eight: assert property (
    $rose(s.card_ready) |-> wake_done == 4'h7 && s.ref_done)
    else $error("wake-up refresh count not eight");

endmodule

// >>> dram_card_host_pkg.sv
// Shared constants and carriers for the memory card host controller.
// Assumes a single 50 MHz clock; all card timing is rounded to whole cycles.
package dram_card_host_pkg;

  localparam int CLK_MHZ = 50;

  // Least time in ns to whole cycles, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Card timing figures
  localparam int T_RP_NS = 40;
  localparam int T_RAS_NS = 60;
  localparam int T_CAS_NS = 15;
  localparam int T_CAC_NS = 25;
  localparam int T_CWD_NS = 50;
  localparam int T_AWD_NS = 65;
  localparam int T_RWD_NS = 80;
  localparam int T_OD_NS = 25;
  localparam int T_CWL_NS = 20;
  localparam int T_INIT_US = 100;
  localparam int T_REF_MS = 64;
  localparam int T_OPEN_MAX_US = 100;
  localparam int REF_ROWS = 512;

  localparam logic [15:0] RP_CYC = 16'(cyc_min(T_RP_NS));
  localparam logic [15:0] RAS_CYC = 16'(cyc_min(T_RAS_NS));
  localparam logic [15:0] CAS_CYC = 16'(cyc_min(T_CAS_NS));
  localparam logic [15:0] CAC_CYC = 16'(cyc_min(T_CAC_NS));
  localparam logic [15:0] CWD_CYC = 16'(cyc_min(T_CWD_NS));
  // Write strobe after column strobe: largest of the three write delays,
  // counted from the column strobe (the row and address ones start earlier)
  localparam logic [15:0] RMW_WE_CYC = 16'(cyc_min(T_RWD_NS));
  localparam logic [15:0] AWD_CYC = 16'(cyc_min(T_AWD_NS));
  localparam logic [15:0] OD_CYC = 16'(cyc_min(T_OD_NS));
  localparam logic [15:0] CWL_CYC = 16'(cyc_min(T_CWL_NS));
  localparam logic [15:0] INIT_CYC = 16'(T_INIT_US * CLK_MHZ);
  localparam logic [15:0] ROW_INTERVAL_CYC = 16'(T_REF_MS * 1000 * CLK_MHZ / REF_ROWS);
  localparam logic [15:0] OPEN_ROW_CYC = 16'(T_OPEN_MAX_US * CLK_MHZ);
  localparam logic [3:0] WAKE_COUNT = 4'h8;

  //////////////////////////////////////////////////////////////////////////////
  // Commands and carriers
  typedef enum logic [2:0] {
    CMD_READ = 3'b000,
    CMD_WRITE_EARLY = 3'b001,
    CMD_WRITE_LATE = 3'b010,
    CMD_READ_MODIFY_WRITE = 3'b011,
    CMD_ROW_ONLY_REFRESH = 3'b100,
    CMD_COLUMN_FIRST_REFRESH = 3'b101,
    CMD_BATTERY_RETENTION_REFRESH = 3'b110,
    CMD_TEST_ENTRY = 3'b111
  } cmd_e;

  typedef struct packed {
    cmd_e cmd;
    logic hidden;
    logic [1:0] bank;
    logic [3:0] lanes;
    logic [8:0] row;
    logic [8:0] col;
    logic [39:0] wdata;
  } request_s;

  typedef struct packed {
    logic [39:0] rdata;
    logic err;
  } answer_s;

  typedef struct packed {
    logic [3:0] ras_n;
    logic [3:0] cas_n;
    logic we_n;
    logic oe_n;
    logic [8:0] multiplexed_address;
    logic [39:0] data_lines_out;
    logic data_lines_drive_n;
  } card_pins_s;

  localparam card_pins_s PINS_IDLE = '{
    ras_n: 4'hf, cas_n: 4'hf, we_n: 1'b1, oe_n: 1'b1,
    multiplexed_address: 9'h000, data_lines_out: 40'h0000000000,
    data_lines_drive_n: 1'b1
  };

endpackage

// >>> refresh_pacer.sv
// Row refresh pacing: one refresh owed per row interval, saturating backlog.
// Assumes taken is a one-cycle pulse per completed refresh.
`timescale 1ns/1ps
module refresh_pacer
  import dram_card_host_pkg::*;
#(
  parameter logic [15:0] ROW_INTERVAL = ROW_INTERVAL_CYC
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic taken,
  output logic due,
  output logic overdue
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [1:0] pending;
    logic due;
    logic overdue;
  } pacer_s;

  pacer_s s;
  pacer_s next_s;
  logic wrap;

  always_comb
  begin
    next_s = s;
    wrap = (s.cnt == ROW_INTERVAL - 16'h0001);
    next_s.cnt = wrap ? 16'h0000 : s.cnt + 16'h0001;
    // A new owed refresh and a taken one in the same cycle cancel
    if (wrap && !taken && s.pending != 2'h3)
    begin
      next_s.pending = s.pending + 2'h1;
    end
    else if (!wrap && taken && s.pending != 2'h0)
    begin
      next_s.pending = s.pending - 2'h1;
    end
    next_s.due = (next_s.pending != 2'h0);
    // Backlog saturated: interval missed, wake-up must be repeated
    next_s.overdue = (next_s.pending == 2'h3);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign due = s.due;
  assign overdue = s.overdue;

  a_owed_counted: assert property (@(posedge clock) disable iff (rst)
    (wrap && !taken && s.pending == 2'h0) |=> due && s.pending == 2'h1)
    else $error("owed refresh not recorded");

endmodule

// >>> dram_card_model.sv
// Behavioural memory card: banked word array, refresh and test counters.
// Assumes registered host pins; resolves the shared data lines for both parties.
`timescale 1ns/1ps
module dram_card_model
  import dram_card_host_pkg::*;
(
  input wire logic clock,
  input wire card_pins_s pins,
  output logic [39:0] data_lines_in,
  output int column_first_count,
  output int row_only_count,
  output int test_entry_count
);
  logic [39:0] mem [logic [21:0]];
  card_pins_s prev;
  logic [8:0] row_at;
  logic [21:0] key;
  logic [39:0] q;
  logic [39:0] last;
  logic reading;
  logic cas_seen;
  logic hid;

  function automatic logic [39:0] merge(input logic [39:0] old, input logic [39:0] d,
      input logic [3:0] cas_n);
    logic [39:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (!cas_n[i]) r[i*10 +: 10] = d[i*10 +: 10];
    return r;
  endfunction

  initial
  begin
    prev = PINS_IDLE;
    {row_at, key, q, last, reading, cas_seen, hid} = '0;
    {column_first_count, row_only_count, test_entry_count} = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clock)
  begin
    if (prev.ras_n == 4'hf && pins.ras_n != 4'hf)
    begin
      row_at = pins.multiplexed_address;
      cas_seen = pins.cas_n != 4'hf;
      if (cas_seen && !pins.we_n && !hid)
        test_entry_count++;
      else if (cas_seen)
        column_first_count++;
    end
    if (prev.ras_n != 4'hf && pins.ras_n == 4'hf)
    begin
      if (!cas_seen)
        row_only_count++;
      hid = pins.cas_n != 4'hf;
    end
    if (pins.ras_n != 4'hf && prev.cas_n == 4'hf && pins.cas_n != 4'hf)
    begin
      cas_seen = 1'b1;
      key = {pins.ras_n, row_at, pins.multiplexed_address};
      if (!mem.exists(key))
        mem[key] = '0;
      if (!pins.we_n)
        mem[key] = merge(mem[key], pins.data_lines_out, pins.cas_n);
      reading <= pins.we_n;
      q <= mem[key];
    end
    if (pins.ras_n != 4'hf && prev.cas_n != 4'hf && pins.cas_n != 4'hf && prev.we_n && !pins.we_n)
      mem[key] = merge(mem[key], pins.data_lines_out, pins.cas_n);
    if (pins.cas_n == 4'hf)
      reading <= 1'b0;
    last <= data_lines_in;
    prev = pins;
  end

  always_comb
  begin
    if (!pins.data_lines_drive_n)
      data_lines_in = pins.data_lines_out;
    else if (reading && pins.cas_n != 4'hf && !pins.oe_n)
      data_lines_in = q;
    else
      data_lines_in = ~last;
  end
endmodule

// >>> tb.sv
// Self-checking bench for the memory card host controller against a card model.
// Assumes a 50 MHz clock and shortened power-up, refresh and open-row counts.
`timescale 1ns/1ps
module tb;
  import dram_card_host_pkg::*;
  localparam logic [15:0] INIT_SHORT = 16'h0014;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic oe_tied_low = 1'b0;
  logic wide_mode = 1'b1;
  logic req_valid = 1'b0;
  request_s req = '0;
  logic req_ready;
  logic ans_valid;
  logic card_ready;
  answer_s ans;
  answer_s got;
  card_pins_s pins;
  logic [39:0] data_lines_in;
  int column_first_count;
  int row_only_count;
  int test_entry_count;
  int failures = 0;
  int samples_checked = 0;

  always #10 clock = ~clock;

  dram_card_host #(.INIT_WAIT(INIT_SHORT), .ROW_INTERVAL(16'h00c8), .OPEN_ROW_LIMIT(16'h0032))
  DUT (.clock(clock), .rst(rst), .wide_mode(wide_mode), .oe_tied_low(oe_tied_low),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .ans_valid(ans_valid),
    .ans(ans), .card_ready(card_ready), .pins(pins), .data_lines_in(data_lines_in));

  dram_card_model card (.clock(clock), .pins(pins), .data_lines_in(data_lines_in),
    .column_first_count(column_first_count), .row_only_count(row_only_count),
    .test_entry_count(test_entry_count));

  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic send(input cmd_e cmd, input logic hid, input logic [1:0] bank,
      input logic [3:0] lanes, input logic [8:0] row, input logic [39:0] d);
    int n;
    @(negedge clock);
    req = '{cmd, hid, bank, lanes, row, 9'h003, d};
    req_valid = 1'b1;
    for (n = 0; n < 2000 && req_ready !== 1'b1; n++)
      @(negedge clock);
    chk("request ready", 40'h1, 40'(req_ready));
    @(negedge clock);
    req_valid = 1'b0;
    for (n = 0; n < 300 && ans_valid !== 1'b1; n++)
      @(negedge clock);
    got = ans;
    chk("answer pulse", 40'h1, 40'(ans_valid));
  endtask

  task automatic rd(input logic [1:0] b, input logic [8:0] r);
    send(CMD_READ, 1'b0, b, 4'hf, r, 40'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic s_wake();
    int n;
    chk("strobes in reset", 40'hf, 40'(pins.ras_n));
    rst = 1'b0;
    repeat (INIT_SHORT - 2) @(negedge clock);
    chk("refresh before wait", 40'h0, 40'(column_first_count));
    for (n = 0; n < 1000 && card_ready !== 1'b1; n++)
      @(negedge clock);
    chk("card ready", 40'h1, 40'(card_ready));
    chk("wake refreshes", 40'h8, 40'(column_first_count));
  endtask

  task automatic s_access_kinds();
    send(CMD_WRITE_EARLY, 1'b0, 2'h0, 4'hf, 9'h005, 40'h1122334455);
    rd(2'h0, 9'h005);
    chk("early write", 40'h1122334455, got.rdata);
    send(CMD_WRITE_LATE, 1'b0, 2'h0, 4'hf, 9'h005, 40'h66778899aa);
    rd(2'h0, 9'h005);
    chk("late write", 40'h66778899aa, got.rdata);
    send(CMD_READ_MODIFY_WRITE, 1'b0, 2'h0, 4'hf, 9'h005, 40'h0a0b0c0d0e);
    chk("modify read", 40'h66778899aa, got.rdata);
    rd(2'h0, 9'h005);
    chk("modify write", 40'h0a0b0c0d0e, got.rdata);
  endtask

  task automatic s_lanes_banks();
    send(CMD_WRITE_EARLY, 1'b0, 2'h0, 4'h5, 9'h005, 40'hffffffffff);
    send(CMD_WRITE_EARLY, 1'b0, 2'h1, 4'hf, 9'h005, 40'h1234512345);
    send(CMD_WRITE_EARLY, 1'b0, 2'h0, 4'hf, 9'h009, 40'h5555aaaa55);
    rd(2'h0, 9'h005);
    chk("lane write", 40'h0a0b0c0d0e | 40'h003ff003ff, got.rdata);
    rd(2'h1, 9'h005);
    chk("second bank", 40'h1234512345, got.rdata);
    rd(2'h0, 9'h009);
    chk("row change", 40'h5555aaaa55, got.rdata);
  endtask

  task automatic s_refused();
    oe_tied_low = 1'b1;
    send(CMD_WRITE_LATE, 1'b0, 2'h0, 4'hf, 9'h009, 40'h0);
    chk("late refused", 40'h1, 40'(got.err));
    send(CMD_READ_MODIFY_WRITE, 1'b0, 2'h0, 4'hf, 9'h009, 40'h0);
    chk("modify refused", 40'h1, 40'(got.err));
    send(CMD_WRITE_EARLY, 1'b0, 2'h0, 4'hf, 9'h009, 40'h0f0f0f0f0f);
    chk("early allowed", 40'h0, 40'(got.err));
    oe_tied_low = 1'b0;
    rd(2'h0, 9'h009);
    chk("after refusal", 40'h0f0f0f0f0f, got.rdata);
  endtask

  task automatic s_refresh_kinds();
    int c;
    int r;
    int t;
    c = column_first_count;
    r = row_only_count;
    t = test_entry_count;
    send(CMD_ROW_ONLY_REFRESH, 1'b0, 2'h0, 4'hf, 9'h000, 40'h0);
    @(negedge clock);
    chk("row only refresh", 40'(r + 1), 40'(row_only_count));
    send(CMD_COLUMN_FIRST_REFRESH, 1'b0, 2'h0, 4'hf, 9'h1ff, 40'h0);
    send(CMD_BATTERY_RETENTION_REFRESH, 1'b0, 2'h0, 4'hf, 9'h1ff, 40'h0);
    chk("column first", 40'h1, 40'(column_first_count >= c + 2));
    send(CMD_TEST_ENTRY, 1'b0, 2'h0, 4'hf, 9'h000, 40'h0);
    @(negedge clock);
    chk("test entry", 40'(t + 1), 40'(test_entry_count));
    rd(2'h0, 9'h009);
    chk("data kept", 40'h0f0f0f0f0f, got.rdata);
  endtask

  task automatic s_hidden_auto();
    int c;
    c = column_first_count;
    send(CMD_WRITE_EARLY, 1'b1, 2'h0, 4'hf, 9'h00c, 40'h9876543210);
    send(CMD_READ, 1'b1, 2'h0, 4'hf, 9'h00c, 40'h0);
    chk("hidden read", 40'h9876543210, got.rdata);
    rd(2'h1, 9'h005);
    chk("hidden refreshes", 40'h1, 40'(column_first_count >= c + 2));
    c = column_first_count;
    repeat (600) @(negedge clock);
    chk("paced refreshes", 40'h1, 40'(column_first_count >= c + 2));
    rd(2'h0, 9'h00c);
    chk("after idle", 40'h9876543210, got.rdata);
  endtask

  // Narrow organization: one row strobe per bank, lanes 0/2 and 1/3 joined
  task automatic s_narrow();
    wide_mode = 1'b0;
    send(CMD_WRITE_EARLY, 1'b0, 2'h2, 4'h1, 9'h005, 40'hffffffffff);
    rd(2'h2, 9'h005);
    chk("narrow bank", 40'h003ff003ff, got.rdata);
    wide_mode = 1'b1;
  endtask

  initial
  begin
    repeat (10) @(negedge clock);
    s_wake();
    s_access_kinds();
    s_lanes_banks();
    s_refused();
    s_refresh_kinds();
    s_narrow();
    s_hidden_auto();
    finish_test();
  end

  initial
  begin
    #400000;
    failures++;
    finish_test();
  end
endmodule
